/* pit_consts.svh */
// register offsets, field positions and reset values of the interval timer
`ifndef PIT_CONSTS_SVH
`define PIT_CONSTS_SVH

`define PIT_ADDR_W        4
`define PIT_DATA_W        16

`define PIT_RELOAD_BASE   4'h0
`define PIT_CTRL_BASE     4'h4
`define PIT_COUNT_BASE    4'h8
`define PIT_STATUS        4'hC

`define PIT_F_CODE_LO     0
`define PIT_F_CODE_HI     2
`define PIT_F_SRC_LO      3
`define PIT_F_SRC_HI      4
`define PIT_F_ENABLE      5
`define PIT_F_SOFT_TRIG   6
`define PIT_F_DMA_EN      7
`define PIT_F_OUT_LO      3

`define PIT_CODE_TC_INT   3'h0
`define PIT_CODE_ONE_SHOT 3'h1
`define PIT_CODE_RATE     3'h2
`define PIT_CODE_SQUARE   3'h3
`define PIT_CODE_SW_STRB  3'h4
`define PIT_CODE_HW_STRB  3'h5
`define PIT_CODE_EVENT    3'h6

`define PIT_RST_CTRL      7'h00
`define PIT_RST_CTRL0     7'h23
`define PIT_RST_RELOAD    16'h0000
`define PIT_RST_BAUD_DIV  16'h000D

`endif

/* pit_counter.sv */
// one 16-bit down counter with its output waveform functions
module pit_counter #(
  parameter int W = 16
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire logic          ce,
  input  wire logic          tick,
  input  wire logic          trig,
  input  wire logic          load,
  input  wire logic [W-1:0]  load_val,
  input  wire logic          enable,
  input  pit_pkg::mode_t     mode,
  output logic      [W-1:0]  count,
  output logic      [W-1:0]  reload,
  output logic               out_level,
  output logic               tc
);

  logic [W-1:0] count_reg, count_next, reload_reg, reload_next;
  logic         run_reg, run_next, out_reg, out_next, low_reg, low_next, tc_reg, tc_next;
  logic         terminal, trig_mode, restart;
  logic [W-1:0] dec;

  assign dec       = count_reg - {{(W-1){1'b0}}, 1'b1};
  assign terminal  = count_reg == {{(W-1){1'b0}}, 1'b1};
  assign trig_mode = (mode == pit_pkg::MODE_ONE_SHOT) || (mode == pit_pkg::MODE_HW_STRB);
  assign restart   = trig && trig_mode && enable;

  always_comb begin
    count_next  = count_reg;
    reload_next = reload_reg;
    run_next    = run_reg;
    out_next    = out_reg;
    low_next    = low_reg;
    tc_next     = 1'b0;
    if (load) begin
      reload_next = load_val;
      count_next  = load_val;
      run_next    = !trig_mode;
      low_next    = 1'b0;
      out_next    = !(mode == pit_pkg::MODE_TC_INT || mode == pit_pkg::MODE_EVENT);
    end else if (restart) begin
      count_next = reload_reg;
      run_next   = 1'b1;
      out_next   = mode != pit_pkg::MODE_ONE_SHOT;
      low_next   = 1'b0;
    end else if (tick && enable) begin
      if (low_reg) begin
        out_next = 1'b1;
        low_next = 1'b0;
      end
      if (run_reg && terminal) begin
        tc_next = 1'b1;
        unique case (mode)
          pit_pkg::MODE_TC_INT, pit_pkg::MODE_EVENT, pit_pkg::MODE_ONE_SHOT: begin
            out_next   = 1'b1;
            run_next   = 1'b0;
            count_next = dec;
          end
          pit_pkg::MODE_RATE: begin
            out_next   = 1'b0;
            low_next   = 1'b1;
            count_next = reload_reg;
          end
          pit_pkg::MODE_SQUARE: begin
            out_next   = 1'b1;
            count_next = reload_reg;
          end
          pit_pkg::MODE_SW_STRB, pit_pkg::MODE_HW_STRB: begin
            out_next   = 1'b0;
            low_next   = 1'b1;
            run_next   = 1'b0;
            count_next = dec;
          end
        endcase
      end else if (run_reg) begin
        count_next = dec;
        if (mode == pit_pkg::MODE_SQUARE) begin
          out_next = dec > (reload_reg >> 1);
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count_reg  <= '0;
      reload_reg <= '0;
      run_reg    <= 1'b0;
      out_reg    <= 1'b1;
      low_reg    <= 1'b0;
      tc_reg     <= 1'b0;
    end else if (ce) begin
      count_reg  <= count_next;
      reload_reg <= reload_next;
      run_reg    <= run_next;
      out_reg    <= out_next;
      low_reg    <= low_next;
      tc_reg     <= tc_next;
    end
  end

  assign count     = count_reg;
  assign reload    = reload_reg;
  assign out_level = out_reg;
  assign tc        = tc_reg;

endmodule : pit_counter

/* pit_edge.sv */
// rising edge detector for a synchronous timer pin
module pit_edge (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic ce,
  input  wire logic pin,
  output logic      rise
);

  logic prev_reg;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prev_reg <= 1'b0;
    end else if (ce) begin
      prev_reg <= pin;
    end
  end

  assign rise = pin & ~prev_reg;

endmodule : pit_edge

/* pit_pin_source.sv */
// event source model driving the two timer input pins
module pit_pin_source (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic [1:0] req,
  output logic      [1:0] tmr_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // pins idle low; a request becomes a pin pulse one cycle later, as a slow source would
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      tmr_in <= 2'h0;
    end else begin
      tmr_in <= req;
    end
  end
endmodule : pit_pin_source

/* pit_pkg.sv */
// types shared by the interval timer modules
package pit_pkg;

  typedef enum logic [6:0] {
    MODE_TC_INT   = 7'h01,
    MODE_ONE_SHOT = 7'h02,
    MODE_RATE     = 7'h04,
    MODE_SQUARE   = 7'h08,
    MODE_SW_STRB  = 7'h10,
    MODE_HW_STRB  = 7'h20,
    MODE_EVENT    = 7'h40
  } mode_t;

  typedef enum logic [1:0] {
    SRC_INTERNAL = 2'h0,
    SRC_PIN      = 2'h1,
    SRC_PRESCALE = 2'h2
  } clk_src_t;

  typedef struct packed {
    logic       dma_en;
    logic       enable;
    clk_src_t   src;
    logic [2:0] code;
  } ctrl_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } reg_req_t;

  function automatic mode_t decode_mode(input logic [2:0] code);
    mode_t m;
    m = MODE_TC_INT;
    unique case (code)
      3'h0:    m = MODE_TC_INT;
      3'h1:    m = MODE_ONE_SHOT;
      3'h2:    m = MODE_RATE;
      3'h3:    m = MODE_SQUARE;
      3'h4:    m = MODE_SW_STRB;
      3'h5:    m = MODE_HW_STRB;
      3'h6:    m = MODE_EVENT;
      default: m = MODE_TC_INT;
    endcase
    return m;
  endfunction : decode_mode

endpackage : pit_pkg

/* programmable_interval_timer.sv */
// three-channel programmable interval timer with register port and timer pins
// Summary of operation
// - three independent timers, each counting with a 16-bit counter
// - timers 0 and 1 each own one input pin and one output pin
// - timer 2 has no pins; prescales timers 0/1 or raises transfer requests
// - terminal-count function raises an interrupt request at terminal count
// - one-shot: output low on trigger or soft command, high at terminal count, retriggerable
// - rate generator: one-period low pulse every N input periods
// - square wave: high for first half of count, low for the rest, repeating
// - software strobe: high after load, one-period low pulse N periods later
// - hardware strobe: one-period low pulse N counts after trigger rise, retriggerable
// - event counter: counts pin events, readable, interrupt after N events
// - live count readable at any time without stopping the count
// - each timer's function selected independently by software
// - after reset timer 0 runs as the serial baud rate generator
`include "pit_consts.svh"

module programmable_interval_timer #(
  parameter int              W        = `PIT_DATA_W,
  parameter int              AW       = `PIT_ADDR_W,
  parameter logic [W-1:0]    BAUD_DIV = `PIT_RST_BAUD_DIV
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_b,
  input  wire logic          ce,
  input  wire logic [AW-1:0] addr,
  input  wire logic [W-1:0]  wr_data,
  input  wire logic          wr_stb,
  input  wire logic          rd_stb,
  output logic      [W-1:0]  rd_data,
  input  wire logic [1:0]    tmr_in,
  output logic      [1:0]    tmr_out,
  output logic      [2:0]    tc_irq,
  output logic               dma_req,
  output logic               baud_clk
);

  localparam int N = 3;

  // bus request gathered for decoding
  pit_pkg::reg_req_t req;

  assign req.wr    = wr_stb;
  assign req.rd    = rd_stb;
  assign req.addr  = addr;
  assign req.wdata = wr_data;

  // per-channel configuration and state
  pit_pkg::ctrl_t    ctrl_reg  [N];
  pit_pkg::ctrl_t    ctrl_next [N];
  pit_pkg::mode_t    mode      [N];
  logic [W-1:0]      count     [N];
  logic [W-1:0]      reload    [N];
  logic [N-1:0]      out_lvl;
  logic [N-1:0]      tc;
  logic [N-1:0]      tick;
  logic [N-1:0]      trig;
  logic [N-1:0]      load;
  logic [N-1:0]      soft_trig;
  logic [N-1:0]      ctrl_hit;
  logic [N-1:0]      reload_hit;
  logic [1:0]        pin_rise;
  logic [W-1:0]      load_val  [N];

  // sticky terminal-count flags
  logic [N-1:0]      flag_reg;
  logic [N-1:0]      flag_next;
  logic [N-1:0]      flag_clr;

  // one-cycle-late actions
  logic              dma_reg;
  logic              boot_reg;
  logic [W-1:0]      rd_data_reg;
  logic [W-1:0]      rd_mux;

  // address decode
  logic              status_hit;
  logic [1:0]        ch_index;
  logic [1:0]        group;
  logic              ch_valid;
  logic [7:0]        ctrl_view;

  assign group      = req.addr[3:2];
  assign ch_index   = req.addr[1:0];
  assign ch_valid   = ch_index != 2'h3;
  assign status_hit = req.addr == `PIT_STATUS;

  // soft trigger bit 6 is a write-only pulse, so it reads back as zero
  assign ctrl_view  = {ctrl_reg[ch_index].dma_en, 1'b0, ctrl_reg[ch_index].enable,
                       ctrl_reg[ch_index].src, ctrl_reg[ch_index].code};

  // timer pins only feed channels 0 and 1
  for (genvar p = 0; p < 2; p++) begin : g_pin
    pit_edge u_edge (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .ce      (ce),
      .pin     (tmr_in[p]),
      .rise    (pin_rise[p])
    );
  end

  for (genvar i = 0; i < N; i++) begin : g_ch
    localparam logic [1:0] IDX = 2'(i);

    assign reload_hit[i] = req.wr && (req.addr == (`PIT_RELOAD_BASE | {2'h0, IDX}));
    assign ctrl_hit[i]   = req.wr && (req.addr == (`PIT_CTRL_BASE | {2'h0, IDX}));

    // a fresh count is loaded by writing the reload register
    assign load[i]       = reload_hit[i] || (i == 0 && boot_reg);
    assign load_val[i]   = (i == 0 && boot_reg) ? BAUD_DIV : req.wdata;
    assign soft_trig[i]  = ctrl_hit[i] && req.wdata[`PIT_F_SOFT_TRIG];

    always_comb begin
      ctrl_next[i] = ctrl_reg[i];
      if (ctrl_hit[i]) begin
        ctrl_next[i].code   = req.wdata[`PIT_F_CODE_HI:`PIT_F_CODE_LO];
        ctrl_next[i].src    = pit_pkg::clk_src_t'(req.wdata[`PIT_F_SRC_HI:`PIT_F_SRC_LO]);
        ctrl_next[i].enable = req.wdata[`PIT_F_ENABLE];
        ctrl_next[i].dma_en = req.wdata[`PIT_F_DMA_EN];
      end
    end

    assign mode[i] = pit_pkg::decode_mode(ctrl_reg[i].code);

    if (i < 2) begin : g_pinned
      // pin serves as clock in event counting or with the pin source selected, else as trigger
      logic pin_clocks;
      assign pin_clocks = ctrl_reg[i].src == pit_pkg::SRC_PIN
                          || mode[i] == pit_pkg::MODE_EVENT;
      assign tick[i] = pin_clocks ? pin_rise[i] :
                       (ctrl_reg[i].src == pit_pkg::SRC_PRESCALE) ? tc[2] :
                       1'b1;
      assign trig[i] = soft_trig[i] || (!pin_clocks && pin_rise[i]);
    end else begin : g_internal
      // no pins: timer 2 always runs from the system clock
      assign tick[i] = 1'b1;
      assign trig[i] = soft_trig[i];
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
        ctrl_reg[i] <= (i == 0) ? pit_pkg::ctrl_t'(`PIT_RST_CTRL0)
                                : pit_pkg::ctrl_t'(`PIT_RST_CTRL);
      end else if (ce) begin
        ctrl_reg[i] <= ctrl_next[i];
      end
    end

    pit_counter #(
      .W (W)
    ) u_cnt (
      .clk_sys   (clk_sys),
      .rst_b     (rst_b),
      .ce        (ce),
      .tick      (tick[i]),
      .trig      (trig[i]),
      .load      (load[i]),
      .load_val  (load_val[i]),
      .enable    (ctrl_reg[i].enable),
      .mode      (mode[i]),
      .count     (count[i]),
      .reload    (reload[i]),
      .out_level (out_lvl[i]),
      .tc        (tc[i])
    );
  end

  // boot load of the baud divisor, one cycle after reset release
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      boot_reg <= 1'b1;
    end else if (ce) begin
      boot_reg <= 1'b0;
    end
  end

  // write-one-to-clear; a terminal count in the same cycle keeps the flag
  assign flag_clr  = (req.wr && status_hit) ? req.wdata[N-1:0] : '0;
  assign flag_next = (flag_reg & ~flag_clr) | tc;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flag_reg <= '0;
    end else if (ce) begin
      flag_reg <= flag_next;
    end
  end

  // transfer request from timer 2 only when enabled for it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dma_reg <= 1'b0;
    end else if (ce) begin
      dma_reg <= tc[2] && ctrl_reg[2].dma_en;
    end
  end

  // read mux; live counts are sampled without disturbing the counter
  always_comb begin
    rd_mux = '0;
    unique case (group)
      2'h0: if (ch_valid) rd_mux = reload[ch_index];
      2'h1: if (ch_valid) rd_mux = W'(ctrl_view);
      2'h2: if (ch_valid) rd_mux = count[ch_index];
      2'h3: if (status_hit) rd_mux = W'({out_lvl, flag_reg});
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_reg <= '0;
    end else if (ce) begin
      rd_data_reg <= req.rd ? rd_mux : '0;
    end
  end

  assign rd_data  = rd_data_reg;
  assign tmr_out  = out_lvl[1:0];
  assign tc_irq   = flag_reg;
  assign dma_req  = dma_reg;
  // timer 0 square wave feeds the serial channels
  assign baud_clk = out_lvl[0];

endmodule : programmable_interval_timer

/* programmable_interval_timer_assertions.sv */
// port checks for the interval timer
module programmable_interval_timer_assertions (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        ce,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wr_data,
  input wire logic        wr_stb,
  input wire logic        rd_stb,
  input wire logic [15:0] rd_data,
  input wire logic [1:0]  tmr_out,
  input wire logic [2:0]  tc_irq,
  input wire logic        dma_req,
  input wire logic        baud_clk
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  sequence reload_write;
    ce && wr_stb && addr < 4'h3;
  endsequence

  sequence read_back(logic [3:0] offs);
    ce && rd_stb && addr == $past(addr) + offs;
  endsequence

  reload_read_a: assert property (reload_write ##1 read_back(4'h0) |=>
    rd_data == $past(wr_data, 2)) else $error("reload readback differs from written value");
  load_count_a: assert property (reload_write ##1 read_back(4'h8) |=>
    rd_data == $past(wr_data, 2)) else $error("count after load differs from written value");
  read_idle_a: assert property ($past(ce) && !$past(rd_stb) |-> rd_data == 16'h0000)
    else $error("read data not zero outside a read answer");
  unmapped_read_a: assert property (ce && rd_stb && addr inside {4'h3, 4'h7, 4'hB, 4'hD}
    |=> rd_data == 16'h0000) else $error("unmapped read returned data");
  ctrl_read_a: assert property (ce && rd_stb && addr inside {[4'h4:4'h6]} |=>
    rd_data[6] == 1'b0) else $error("soft trigger bit read back as set");
  irq_sticky_a: assert property ((|($past(tc_irq) & ~tc_irq)) |->
    $past(wr_stb) && $past(addr) == 4'hC) else $error("interrupt flag dropped without a clear");
  dma_flag_a: assert property (dma_req |-> ##[0:1] tc_irq[2])
    else $error("transfer request without timer 2 terminal flag");
  baud_same_a: assert property (baud_clk == tmr_out[0])
    else $error("baud clock differs from timer 0 output");
endmodule : programmable_interval_timer_assertions

bind programmable_interval_timer programmable_interval_timer_assertions u_chk (.clk_sys, .rst_b,
  .ce, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data, .tmr_out, .tc_irq, .dma_req, .baud_clk);

/* programmable_interval_timer_tb.sv */
// self-checking bench for the interval timer
module programmable_interval_timer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys = 1'b0;
  logic        rst_b   = 1'b0;
  logic        ce      = 1'b1;
  logic [3:0]  addr    = 4'h0;
  logic [15:0] wr_data = 16'h0000;
  logic        wr_stb  = 1'b0;
  logic        rd_stb  = 1'b0;
  logic [1:0]  req     = 2'h0;
  logic [15:0] rd_data;
  logic [15:0] seen;
  logic [15:0] c1;
  logic [1:0]  tmr_in;
  logic [1:0]  tmr_out;
  logic [2:0]  tc_irq;
  logic        dma_req;
  logic        baud_clk;
  int          mismatches = 0;
  int          cmp_count  = 0;
  int          n;

  always #20 clk_sys = ~clk_sys;

  programmable_interval_timer u_programmable_interval_timer (.clk_sys, .rst_b, .ce, .addr,
    .wr_data, .wr_stb, .rd_stb, .rd_data, .tmr_in, .tmr_out, .tc_irq, .dma_req, .baud_clk);
  pit_pin_source u_pit_pin_source (.clk_sys, .rst_b, .req, .tmr_in);

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // seen holds the read answer that stood during the cycle just ended
  task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
    wr_stb  <= w;
    rd_stb  <= r;
    addr    <= a;
    wr_data <= d;
    @(posedge clk_sys);
    seen = rd_data;
  endtask : bus

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    bus(1'b1, 1'b0, a, d);
    bus(1'b0, 1'b0, a, d);
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    bus(1'b0, 1'b1, a, 16'h0000);
    bus(1'b0, 1'b0, a, 16'h0000);
    chk($sformatf("register %h", a), exp, seen);
  endtask : rd

  task automatic wait_lvl(input int ch, input logic lvl, output int k);
    k = 0;
    while (tmr_out[ch] !== lvl && k < 300) begin
      @(posedge clk_sys);
      k++;
    end
  endtask : wait_lvl

  task automatic span(input int ch, input logic lvl, output int k);
    k = 0;
    while (tmr_out[ch] === lvl && k < 300) begin
      @(posedge clk_sys);
      k++;
    end
  endtask : span

  task automatic pulse(input int ch);
    req[ch] <= 1'b1;
    @(posedge clk_sys);
    req[ch] <= 1'b0;
  endtask : pulse

  task automatic give_verdict();
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #200000;
    mismatches++;
    give_verdict();
  end

  initial begin
    repeat (20) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(4'h4, 16'h0023);
    rd(4'h5, 16'h0000);
    rd(4'h1, 16'h0000);
    wr(4'h3, 16'hFFFF);
    rd(4'h3, 16'h0000);
    wr(4'h5, 16'h0022);
    bus(1'b1, 1'b0, 4'h1, 16'h0003);
    bus(1'b0, 1'b1, 4'h9, 16'h0000);
    bus(1'b0, 1'b0, 4'h9, 16'h0000);
    chk("count after load", 16'h0003, seen);
    bus(1'b0, 1'b1, 4'h9, 16'h0000);
    bus(1'b0, 1'b1, 4'h9, 16'h0000);
    c1 = seen;
    bus(1'b0, 1'b0, 4'h9, 16'h0000);
    chk("live count", (c1 == 16'h0001) ? 16'h0003 : c1 - 16'h0001, seen);
    wait_lvl(1, 1'b0, n);
    span(1, 1'b0, n);
    chk("rate low width", 16'h0001, 16'(n));
    span(1, 1'b1, n);
    chk("rate high width", 16'h0002, 16'(n));
    chk("timer 1 flag", 16'h0001, {15'h0000, tc_irq[1]});
    wr(4'h5, 16'h0000);
    wr(4'hC, 16'h0002);
    chk("timer 1 flag cleared", 16'h0000, {15'h0000, tc_irq[1]});
    // one-shot: armed high, soft trigger twice so the second restarts the count
    wr(4'h5, 16'h0021);
    wr(4'h1, 16'h0004);
    chk("one-shot armed", 16'h0001, {15'h0000, tmr_out[1]});
    wr(4'h5, 16'h0061);
    wr(4'h5, 16'h0061);
    span(1, 1'b0, n);
    chk("one-shot retrigger low", 16'h0004, 16'(n));
    pulse(1);
    wait_lvl(1, 1'b0, n);
    chk("one-shot pin delay", 16'h0002, 16'(n));
    wr(4'h5, 16'h0024);
    wr(4'h1, 16'h0004);
    wait_lvl(1, 1'b0, n);
    chk("soft strobe delay", 16'h0004, 16'(n));
    span(1, 1'b0, n);
    chk("soft strobe width", 16'h0001, 16'(n));
    wr(4'h5, 16'h0025);
    wr(4'h1, 16'h0004);
    pulse(1);
    repeat (2) @(posedge clk_sys);
    pulse(1);
    wait_lvl(1, 1'b0, n);
    chk("pin strobe delay", 16'h0006, 16'(n));
    span(1, 1'b0, n);
    chk("pin strobe width", 16'h0001, 16'(n));
    wr(4'h5, 16'h0000);
    wr(4'hC, 16'h0002);
    wr(4'h5, 16'h0026);
    wr(4'h1, 16'h0003);
    pulse(1);
    repeat (2) @(posedge clk_sys);
    pulse(1);
    repeat (2) @(posedge clk_sys);
    rd(4'h9, 16'h0001);
    pulse(1);
    repeat (4) @(posedge clk_sys);
    chk("event flag", 16'h0001, {15'h0000, tc_irq[1]});
    rd(4'h9, 16'h0000);
    wr(4'h6, 16'h00A0);
    rd(4'h6, 16'h00A0);
    bus(1'b1, 1'b0, 4'h2, 16'h0005);
    bus(1'b0, 1'b1, 4'h2, 16'h0000);
    bus(1'b0, 1'b0, 4'h2, 16'h0000);
    chk("timer 2 reload", 16'h0005, seen);
    // the request is a single pulse a few cycles after the load, so poll at once
    n = 0;
    while (dma_req !== 1'b1 && n < 40) begin
      @(posedge clk_sys);
      n++;
    end
    chk("transfer request seen", 16'h0001, {15'h0000, dma_req});
    repeat (3) @(posedge clk_sys);
    chk("timer 2 flag", 16'h0001, {15'h0000, tc_irq[2]});
    rd(4'hA, 16'h0000);
    chk("timer 0 flag", 16'h0001, {15'h0000, tc_irq[0]});
    // clock enable low freezes the count: 8 loaded, one tick, then four frozen edges
    wr(4'h2, 16'h0008);
    ce <= 1'b0;
    repeat (4) @(posedge clk_sys);
    ce <= 1'b1;
    rd(4'hA, 16'h0007);
    // timer 1 clocked by timer 2 terminal pulses, one every two cycles
    wr(4'hC, 16'h0002);
    wr(4'h5, 16'h0030);
    wr(4'h6, 16'h0022);
    wr(4'h2, 16'h0002);
    wr(4'h1, 16'h0003);
    repeat (2) @(posedge clk_sys);
    rd(4'h9, 16'h0001);
    repeat (2) @(posedge clk_sys);
    chk("prescaled flag", 16'h0001, {15'h0000, tc_irq[1]});
    // timer 0 must still run its boot square wave after the others were reprogrammed
    wait_lvl(0, 1'b1, n);
    wait_lvl(0, 1'b0, n);
    span(0, 1'b0, n);
    chk("baud low span", 16'h0006, 16'(n));
    span(0, 1'b1, n);
    chk("baud high span", 16'h0007, 16'(n));
    give_verdict();
  end
endmodule : programmable_interval_timer_tb
